// ==== pm_engine.sv ====
/*
 * measurement engine: sequences shunt and bus samples, averages them,
 * scales current and power from calibration, serves the register link.
 * assumes adc sample words are on pclk and valid whenever taken.
 */
`timescale 1ns/100ps
module pm_engine #(
  parameter int CONV_CYC = pm_pkg::CONV12_CYC // 12-bit sample time
) (
  input  wire logic        pclk,       // clock
  input  wire logic        presetn,    // async reset, low
  pm_link_if.dev           link,       // register link
  input  wire logic        conv_n,     // convert line, low starts
  input  wire logic [15:0] shunt_adc,  // shunt sample, 10uV steps
  input  wire logic [12:0] bus_adc,    // bus sample, 4mV steps
  output logic             shunt_take, // pulse: shunt sample taken
  output logic             bus_take,   // pulse: bus sample taken
  output logic             cnvr        // conversion ready level
);
  typedef enum logic [2:0] {S_IDLE, S_SHUNT, S_BUS, S_MUL, S_PWR} st_t;
  st_t         st_r;         // sequencer state
  logic [15:0] cfg_r;        // configuration
  logic [15:0] cal_r;        // calibration
  logic [15:0] shunt_r;      // shunt result
  logic [12:0] bus_r;        // bus result
  logic [15:0] cur_r;        // current result
  logic [15:0] pwr_r;        // power result
  logic        cnvr_r;       // conversion ready
  logic        ovf_r;        // math overflow
  logic [31:0] tmr_r;        // sample timer
  logic [7:0]  cnt_r;        // samples left
  logic signed [23:0] acc_r; // sample sum
  logic        cv1_r, cv2_r; // convert line sync
  logic        cv3_r;        // convert line, one cycle later
  logic        pwr_due_r;    // power step follows current step
  logic        ack_r;        // link answer
  logic [15:0] rdata_r;      // link read data
  logic signed [31:0] prod_r; // shunt times cal
  // averaging count and sample time from a 4-bit adc field
  function automatic logic [7:0] avg_n(input logic [3:0] f);
    avg_n = f[3] ? 8'(1 << f[2:0]) : 8'h01;
  endfunction
  function automatic logic [2:0] avg_sh(input logic [3:0] f);
    avg_sh = f[3] ? f[2:0] : 3'h0;
  endfunction
  function automatic logic [31:0] smp_cyc(input logic [3:0] f);
    smp_cyc = f[3] ? 32'(CONV_CYC) : 32'(CONV_CYC >> (3 - f[1:0]));
  endfunction
  // decoded configuration
  wire [3:0]  sadc = cfg_r[pm_pkg::CFG_SADC_LO +: 4]; // shunt adc
  wire [3:0]  badc = cfg_r[pm_pkg::CFG_BADC_LO +: 4]; // bus adc
  wire [1:0]  pg   = cfg_r[pm_pkg::CFG_PG_LO +: 2];   // shunt gain
  wire [2:0]  mode = cfg_r[pm_pkg::CFG_MODE_LO +: 3]; // mode
  wire        brng = cfg_r[pm_pkg::CFG_BRNG_BIT];     // bus range
  // shunt limit: 40mV times 1,2,4,8 gives up to 320mV
  wire [15:0] sh_fs = pm_pkg::SHUNT_FS_40MV << pg;
  // bus limit: 16V or 32V
  wire [12:0] bus_fs = brng ? pm_pkg::BUS_FS_32V : pm_pkg::BUS_FS_16V;
  // link decode
  wire        wr_hit = link.req & link.wr & ~ack_r;  // write accepted
  wire        rd_hit = link.req & ~link.wr & ~ack_r; // read accepted
  wire        cfg_wr = wr_hit & (link.ptr == pm_pkg::PTR_CFG);
  wire        cal_wr = wr_hit & (link.ptr == pm_pkg::PTR_CAL);
  wire        soft_rst = cfg_wr & link.wdata[pm_pkg::CFG_RST_BIT];
  wire        off_mode = (link.wdata[2:0] == 3'h0) | (link.wdata[2:0] == 3'h4);
  wire        trig_mode = ~mode[2] & (mode[1:0] != 2'h0);
  wire        idle_go = mode[2] ? (mode[1:0] != 2'h0) : (trig_mode & ~cv2_r);
  wire        conv_fall = trig_mode & cv3_r & ~cv2_r & (st_r == S_IDLE); // new trigger
  wire        tick = (tmr_r == 32'h0);               // sample instant
  wire        last = tick & (cnt_r == 8'h01);        // last sample
  wire signed [23:0] acc_nx = acc_r + (st_r == S_SHUNT ?
                        24'(signed'(shunt_adc)) : 24'({11'h0, bus_adc}));
  wire signed [23:0] sh_avg = acc_nx >>> avg_sh(sadc); // shunt mean
  wire [23:0] bus_avg = acc_nx >> avg_sh(badc);        // bus mean
  wire signed [16:0] fs_s = 17'({1'b0, sh_fs});         // signed limit
  wire        cur_neg = prod_r[31];
  wire signed [31:0] cur_full = prod_r >>> pm_pkg::CAL_SHIFT;
  wire        cur_ovf = (cur_full > 32'sd32767) | (cur_full < -32'sd32768);
  wire [15:0] cur_abs = cur_r[15] ? 16'(-cur_r) : cur_r;
  wire [31:0] pwr_full = (32'(cur_abs) * 32'(bus_r)) / 32'(pm_pkg::POWER_DIV);

  // conversion line passes two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cv1_r <= 1'b1;
      cv2_r <= 1'b1;
      cv3_r <= 1'b1;
    end else begin
      cv1_r <= conv_n;
      cv2_r <= cv1_r;
      cv3_r <= cv2_r;
    end
  end

  // configuration and calibration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= pm_pkg::CFG_RST;
      cal_r <= pm_pkg::CAL_RST;
    end else if (soft_rst) begin
      cfg_r <= pm_pkg::CFG_RST; // soft reset, bit self-clears
      cal_r <= pm_pkg::CAL_RST;
    end else begin
      if (cfg_wr) cfg_r <= link.wdata & 16'h7fff; // separate sadc, badc
      if (cal_wr) cal_r <= link.wdata;
    end
  end

  // sequencer: shunt samples, then bus samples, then background math
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      tmr_r <= 32'h0;
      cnt_r <= 8'h0;
      acc_r <= 24'sh0;
    end else if (soft_rst || (cfg_wr && !idle_go && st_r != S_IDLE)) begin
      st_r <= S_IDLE; // abort to idle on soft reset, or on reconfigure while idle_go is low
    end else begin
      unique case (st_r)
        S_IDLE: if (idle_go && !(trig_mode && !cfg_wr && !cv2_r && cnvr_r)) begin
          st_r <= mode[0] ? S_SHUNT : S_BUS;
          tmr_r <= mode[0] ? smp_cyc(sadc) : smp_cyc(badc);
          cnt_r <= mode[0] ? avg_n(sadc) : avg_n(badc);
          acc_r <= 24'sh0;
        end
        S_SHUNT: if (tick) begin
          acc_r <= last ? 24'sh0 : acc_nx;
          cnt_r <= last ? avg_n(badc) : cnt_r - 8'h01;
          tmr_r <= last ? smp_cyc(badc) : smp_cyc(sadc);
          if (last) st_r <= mode[1] ? S_BUS : S_MUL;
        end else tmr_r <= tmr_r - 32'h1;
        S_BUS: if (tick) begin
          acc_r <= last ? 24'sh0 : acc_nx;
          cnt_r <= cnt_r - 8'h01;
          tmr_r <= smp_cyc(badc);
          if (last) st_r <= S_MUL;
        end else tmr_r <= tmr_r - 32'h1;
        S_MUL: st_r <= S_PWR;
        S_PWR: st_r <= S_IDLE;
      endcase
    end
  end

  // results: clamp to range, then scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shunt_r <= 16'h0;
      bus_r <= 13'h0;
      prod_r <= 32'sh0;
      cur_r <= 16'h0;
      pwr_r <= 16'h0;
      ovf_r <= 1'b0;
      pwr_due_r <= 1'b0;
    end else if (soft_rst) begin
      cur_r <= 16'h0;
      pwr_r <= 16'h0;
      ovf_r <= 1'b0;
      pwr_due_r <= 1'b0;
    end else begin
      pwr_due_r <= (st_r == S_PWR); // power one step after current
      if (st_r == S_SHUNT && last)
        shunt_r <= sh_avg > 24'(fs_s) ? sh_fs : sh_avg < -24'(fs_s) ?
                   16'(-sh_fs) : sh_avg[15:0];
      if (st_r == S_BUS && last)
        bus_r <= bus_avg > 24'(bus_fs) ? bus_fs : bus_avg[12:0];
      if (st_r == S_MUL)
        prod_r <= 32'(signed'(shunt_r)) * 32'(signed'({1'b0, cal_r}));
      if (st_r == S_PWR) begin
        cur_r <= cur_ovf ? (cur_neg ? 16'h8000 : pm_pkg::CUR_MAX) : cur_full[15:0];
        ovf_r <= cur_ovf;
      end
      if (pwr_due_r)
        pwr_r <= pwr_full > 32'h0000ffff ? 16'hffff : pwr_full[15:0];
    end
  end

  // conversion ready: set after math, set wins over clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnvr_r <= 1'b0;
    else if (pwr_due_r) cnvr_r <= 1'b1;
    else if ((cfg_wr && !off_mode) || soft_rst || conv_fall) cnvr_r <= 1'b0;
  end

  // link answer, one cycle after request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0;
    end else begin
      ack_r <= wr_hit | rd_hit;
      if (rd_hit) begin
        unique case (link.ptr)
          pm_pkg::PTR_CFG: rdata_r <= cfg_r;
          pm_pkg::PTR_SHUNT: rdata_r <= shunt_r;
          pm_pkg::PTR_BUS: rdata_r <= {bus_r, 1'b0, cnvr_r, ovf_r};
          pm_pkg::PTR_POWER: rdata_r <= pwr_r;
          pm_pkg::PTR_CURRENT: rdata_r <= cur_r;
          pm_pkg::PTR_CAL: rdata_r <= cal_r;
          default: rdata_r <= 16'h0; // unmapped reads zero
        endcase
      end
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign shunt_take = (st_r == S_SHUNT) & tick;
  assign bus_take = (st_r == S_BUS) & tick;
  assign cnvr = cnvr_r;
endmodule // pm_engine

// ==== pm_pkg.sv ====
/*
 * constants shared by the measurement engine and its host port.
 * assumes one 250 MHz clock for both ends and a 16-bit register link.
 */
// What this block does
// - shunt then bus sampled; gap scales with averaging
// - current and power computed after conversions, background
// - shunt gain widens range x2, x4, x8
// - bus range selectable: 16V or 32V
// - unity gain 40mV, divide-by-two gives 80mV
// - separate resolution and averaging for shunt, bus
// - defaults: continuous, 12-bit, 320mV, 32V
// - current, power meaningful only after calibration written
// - host rewrites settings after every power-up
// - host calibration = trunc(0.04096 / (step*shunt))
// - bus step 4mV; power step 20x current
// - current saturates at +32767 steps
// - host picks step between max/32767 and max/4096
// - host may trim calibration by measured current
// - calibration resets zero, so current, power zero
package pm_pkg;
  // register pointers on the link
  localparam logic [7:0] PTR_CFG = 8'h00; // configuration
  localparam logic [7:0] PTR_SHUNT = 8'h01; // shunt result
  localparam logic [7:0] PTR_BUS = 8'h02; // bus result
  localparam logic [7:0] PTR_POWER = 8'h03; // power result
  localparam logic [7:0] PTR_CURRENT = 8'h04; // current result
  localparam logic [7:0] PTR_CAL = 8'h05; // calibration
  // reset values
  localparam logic [15:0] CFG_RST = 16'h399f; // default configuration
  localparam logic [15:0] CAL_RST = 16'h0000; // calibration zero
  // configuration fields
  localparam int CFG_RST_BIT = 15; // self-clearing soft reset
  localparam int CFG_BRNG_BIT = 13; // bus range select
  localparam int CFG_PG_LO = 11; // shunt gain field, 2 bits
  localparam int CFG_BADC_LO = 7; // bus adc field, 4 bits
  localparam int CFG_SADC_LO = 3; // shunt adc field, 4 bits
  localparam int CFG_MODE_LO = 0; // mode field, 3 bits
  // bus result fields
  localparam int BUS_DATA_LO = 3; // 13-bit result at [15:3]
  localparam int BUS_CNVR_BIT = 1; // conversion ready
  localparam int BUS_OVF_BIT = 0; // math overflow
  // full scale in result steps (shunt 10uV, bus 4mV)
  localparam logic [15:0] SHUNT_FS_40MV = 16'h0fa0; // 4000 steps
  localparam logic [12:0] BUS_FS_16V = 13'h0fa0; // 4000 steps
  localparam logic [12:0] BUS_FS_32V = 13'h1f40; // 8000 steps
  localparam int CAL_SHIFT = 12; // divide by 4096
  localparam logic [15:0] CUR_MAX = 16'h7fff; // 32767 steps
  localparam int POWER_DIV = 5000; // 20 x step over 4mV
  // timing: worst gap, 12-bit with 128 samples
  localparam int GAP_MAX_MS = 68; // milliseconds
  localparam int GAP_AVG_N = 128; // samples in that gap
  localparam int CLK_MHZ = 250; // pclk rate
  localparam int CONV12_CYC = GAP_MAX_MS * 1000 * CLK_MHZ / GAP_AVG_N;
  // host apb map (byte offsets)
  localparam logic [7:0] A_PTR = 8'h00; // link pointer
  localparam logic [7:0] A_WDATA = 8'h04; // write data
  localparam logic [7:0] A_CTRL = 8'h08; // bit0 go, bit1 write
  localparam logic [7:0] A_STAT = 8'h0c; // bit0 busy, bit1 done
  localparam logic [7:0] A_RDATA = 8'h10; // last read data
endpackage

// ==== pm_link_if.sv ====
/*
 * register link between host port and measurement engine.
 * assumes both ends on pclk; one request outstanding at a time.
 */
`timescale 1ns/100ps
interface pm_link_if;
  logic        req;   // request, held until ack
  logic        wr;    // 1 write, 0 read
  logic [7:0]  ptr;   // register pointer
  logic [15:0] wdata; // write data
  logic        ack;   // one-cycle answer
  logic [15:0] rdata; // read data, valid with ack
  modport dev (input req, wr, ptr, wdata, output ack, rdata);
  modport host (output req, wr, ptr, wdata, input ack, rdata);
endinterface // pm_link_if

// ==== pm_host.sv ====
/*
 * host port: apb slave whose registers order single link transfers.
 * assumes software computes calibration and rewrites it after power-up.
 */
`timescale 1ns/100ps
module pm_host (
  input  wire logic        pclk,    // clock
  input  wire logic        presetn, // async reset, low
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb enable
  input  wire logic        pwrite,  // apb direction
  input  wire logic [7:0]  paddr,   // apb byte address
  input  wire logic [31:0] pwdata,  // apb write data
  output logic [31:0]      prdata,  // apb read data
  output logic             pready,  // apb ready
  output logic             pslverr, // apb error
  pm_link_if.host          link     // register link
);
  logic [7:0]  ptr_r;   // link pointer
  logic [15:0] wdat_r;  // link write data
  logic        wr_r;    // transfer is a write
  logic        busy_r;  // transfer in flight
  logic        done_r;  // transfer finished
  logic [15:0] rdat_r;  // last read data
  // apb decode
  wire acc  = psel & penable;
  wire wacc = acc & pwrite;
  wire go   = wacc & (paddr == pm_pkg::A_CTRL) & pwdata[0] & ~busy_r;
  wire hit  = (paddr == pm_pkg::A_PTR) | (paddr == pm_pkg::A_WDATA) |
              (paddr == pm_pkg::A_CTRL) | (paddr == pm_pkg::A_STAT) |
              (paddr == pm_pkg::A_RDATA);
  wire [31:0] rd_mux =
    paddr == pm_pkg::A_PTR   ? {24'h0, ptr_r} :
    paddr == pm_pkg::A_WDATA ? {16'h0, wdat_r} :
    paddr == pm_pkg::A_STAT  ? {30'h0, done_r, busy_r} :
    paddr == pm_pkg::A_RDATA ? {16'h0, rdat_r} : 32'h0;

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= 8'h0;
      wdat_r <= 16'h0;
      wr_r <= 1'b0;
    end else begin
      if (wacc && paddr == pm_pkg::A_PTR && !busy_r) ptr_r <= pwdata[7:0];
      if (wacc && paddr == pm_pkg::A_WDATA && !busy_r) wdat_r <= pwdata[15:0];
      if (go) wr_r <= pwdata[1];
    end
  end

  // link transfer: request held until ack; done set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdat_r <= 16'h0;
    end else begin
      if (go) busy_r <= 1'b1;
      else if (link.ack) busy_r <= 1'b0;
      if (busy_r && link.ack) done_r <= 1'b1;
      else if (go) done_r <= 1'b0;
      if (busy_r && link.ack && !wr_r) rdat_r <= link.rdata;
    end
  end

  // apb read data registered at the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end

  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign link.req = busy_r & ~link.ack;
  assign link.wr = wr_r;
  assign link.ptr = ptr_r;
  assign link.wdata = wdat_r;
endmodule // pm_host

// ==== pm_link_asserts.sv ====
/*
 * checker for the register link, the apb port and the sampling pulses.
 * assumes one clock and an instance beside the link, engine on CONV_CYC 8.
 */
`timescale 1ns/100ps
module pm_link_asserts (
  input wire logic        pclk,       // clock
  input wire logic        presetn,    // async reset, low
  input wire logic        req,        // link request
  input wire logic        wr,         // link direction
  input wire logic [7:0]  ptr,        // link pointer
  input wire logic [15:0] wdata,      // link write data
  input wire logic        ack,        // link answer
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb enable
  input wire logic [7:0]  paddr,      // apb address
  input wire logic        pready,     // apb ready
  input wire logic        pslverr,    // apb error
  input wire logic        shunt_take, // shunt sample pulse
  input wire logic        bus_take,   // bus sample pulse
  input wire logic        cnvr        // conversion ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mapped host registers
  wire addr_hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  // answer is one pulse, request drops with it
  sequence s_answer;
    ack ##1 (!ack && !req);
  endsequence
  property p_req_answer;
    $rose(req) |=> s_answer;
  endproperty
  a_req_answer: assert property (p_req_answer) else $error("link request not answered");
  property p_req_hold;
    req |=> ack && $stable(wr) && $stable(ptr) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("link request changed early");
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_apb_ready;
    psel && penable |-> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb wait state");
  property p_apb_err;
    psel && penable |-> pslverr == !addr_hit;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("apb error flag wrong");
  property p_take_excl;
    !(shunt_take && bus_take);
  endproperty
  a_take_excl: assert property (p_take_excl) else $error("two samples at once");
  property p_take_gap;
    shunt_take |=> (!shunt_take && !bus_take) [*7];
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("sample time too short");
  property p_cnvr_rise;
    $rose(cnvr) |-> $past(bus_take, 4) || $past(shunt_take, 4);
  endproperty
  a_cnvr_rise: assert property (p_cnvr_rise) else $error("ready not after bus");
endmodule // pm_link_asserts

// ==== testbench.sv ====
/*
 * testbench: host port and engine joined by the link, driven over apb.
 * assumes CONV_CYC 8, zero wait apb, adc words held steady.
 */
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [15:0] m; logic [15:0] v;} exp_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic        conv_n = 1; // convert line, idle high
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, shunt_take, bus_take, cnvr;
  logic [15:0] shunt_adc = 0, sh, cal, cur, cfg;
  logic [12:0] bus_adc = 0, bv;
  int          num_errors = 0, checks = 0;
  int unsigned prod;
  exp_t        expq[$];
  exp_t        e;
  pm_link_if link ();
  pm_host i_pm_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  pm_engine #(.CONV_CYC(8)) i_pm_engine (.pclk(pclk), .presetn(presetn), .link(link),
    .conv_n(conv_n), .shunt_adc(shunt_adc), .bus_adc(bus_adc), .shunt_take(shunt_take),
    .bus_take(bus_take), .cnvr(cnvr));
  pm_link_asserts i_asserts (.pclk(pclk), .presetn(presetn), .req(link.req), .wr(link.wr),
    .ptr(link.ptr), .wdata(link.wdata), .ack(link.ack), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .shunt_take(shunt_take),
    .bus_take(bus_take), .cnvr(cnvr));
  // clock, 4 ns
  always #2 pclk = ~pclk;
  // verdict and end of run
  task give_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // counted timeout
  task hang;
    num_errors++;
    give_verdict();
  endtask
  // compare link read data under a mask
  task cmp16(input logic [7:0] p, input exp_t x, input logic [15:0] got);
    checks++;
    if ((got & x.m) !== x.v) begin
      num_errors++;
      $display("Error link reg %h: expected %h seen %h", p, x.v, got & x.m);
    end
  endtask
  // compare apb error flag
  task cmp1(input logic [7:0] a, input logic x, input logic got);
    checks++;
    if (got !== x) begin
      num_errors++;
      $display("Error pslverr at %h: expected %b seen %b", a, x, got);
    end
  endtask
  // watcher: link answers and apb error flag
  always @(posedge pclk) begin
    if (link.ack === 1'b1 && link.wr === 1'b0) begin
      e = expq.pop_front();
      cmp16(link.ptr, e, link.rdata);
    end
    if (psel && penable)
      cmp1(paddr, !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}), pslverr);
  end
  // one apb transfer, entered just after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    r = prdata;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  // one link transfer through the host registers
  task xfer(input logic w, input logic [7:0] p, input logic [15:0] d);
    int n;
    apb(1, pm_pkg::A_PTR, {24'h0, p});
    apb(1, pm_pkg::A_WDATA, {16'h0, d});
    apb(1, pm_pkg::A_CTRL, {30'h0, w, 1'b1});
    n = 0;
    do begin
      apb(0, pm_pkg::A_STAT, 0);
      n++;
    end while (r[1] !== 1'b1 && n < 50);
    if (n >= 50) hang();
  endtask
  // link read with noted expectation
  task rd(input logic [7:0] p, input logic [15:0] m, input logic [15:0] v);
    expq.push_back('{m, v});
    xfer(0, p, 16'h0);
  endtask
  // wait for a whole conversion started after the last change
  task settle;
    int k, n;
    k = 0;
    n = 0;
    while (k < 2 && n < 5000) begin
      @(negedge pclk);
      n++;
      if (bus_take === 1'b1) k++;
    end
    while (cnvr !== 1'b1 && n < 5000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 5000) hang();
    @(posedge pclk);
  endtask
  // one pulse on the convert line, then wait for ready
  task trig;
    int n;
    n = 0;
    conv_n <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (cnvr !== 1'b0 && n < 5000);
    conv_n <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (cnvr !== 1'b1 && n < 5000);
    if (n >= 5000) hang();
  endtask
  initial begin
    void'($urandom(4));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    shunt_adc <= 16'h1234;
    bus_adc <= 13'h0abc;
    settle();
    rd(pm_pkg::PTR_CFG, 16'hffff, pm_pkg::CFG_RST);
    rd(pm_pkg::PTR_SHUNT, 16'hffff, 16'h1234);
    rd(pm_pkg::PTR_BUS, 16'hfff8, {13'h0abc, 3'b000});
    rd(pm_pkg::PTR_CAL, 16'hffff, 16'h0000);
    rd(pm_pkg::PTR_CURRENT, 16'hffff, 16'h0000);
    rd(pm_pkg::PTR_POWER, 16'hffff, 16'h0000);
    apb(0, 8'h14, 0);
    // gain and bus range, inputs beyond every clamp
    for (int i = 0; i < 8; i++) begin
      cfg = {2'b00, i[0], i[2:1], 4'b0011, 4'b0011, 3'b111};
      shunt_adc <= 16'h7fff;
      bus_adc <= 13'h1fff;
      xfer(1, pm_pkg::PTR_CFG, cfg);
      settle();
      rd(pm_pkg::PTR_CFG, 16'hffff, cfg);
      rd(pm_pkg::PTR_SHUNT, 16'hffff, 16'd4000 << i[2:1]);
      rd(pm_pkg::PTR_BUS, 16'hfff8, (i[0] ? 16'd8000 : 16'd4000) << 3);
    end
    xfer(1, pm_pkg::PTR_CFG, pm_pkg::CFG_RST);
    // calibration scaling, random samples
    for (int i = 0; i < 4; i++) begin
      sh = 16'($urandom_range(1, 32000));
      bv = 13'($urandom_range(0, 8000));
      cal = (i == 0) ? 16'h1000 : 16'($urandom_range(1, 65535));
      if (i == 3) sh = 16'd32000;
      if (i == 3) cal = 16'hffff;
      shunt_adc <= sh;
      bus_adc <= bv;
      xfer(1, pm_pkg::PTR_CAL, cal);
      settle();
      prod = (sh * cal) >> 12;
      cur = (prod > 32767) ? 16'h7fff : prod[15:0];
      prod = cur * bv / 5000;
      rd(pm_pkg::PTR_SHUNT, 16'hffff, sh);
      rd(pm_pkg::PTR_BUS, 16'hfff8, {bv, 3'b000});
      rd(pm_pkg::PTR_CURRENT, 16'hffff, cur);
      rd(pm_pkg::PTR_POWER, 16'hffff, (prod > 65535) ? 16'hffff : prod[15:0]);
    end
    // triggered mode with averaging; second write aborts any running conversion
    cfg = {3'b001, 2'b11, 4'b1001, 4'b1010, 3'b011};
    repeat (2) xfer(1, pm_pkg::PTR_CFG, cfg);
    for (int i = 0; i < 2; i++) begin
      sh = 16'($urandom_range(1, 32000));
      bv = 13'($urandom_range(0, 8000));
      shunt_adc <= sh;
      bus_adc <= bv;
      trig();
      rd(pm_pkg::PTR_SHUNT, 16'hffff, sh);
      rd(pm_pkg::PTR_BUS, 16'hfff8, {bv, 3'b000});
    end
    // soft reset restores defaults
    xfer(1, pm_pkg::PTR_CFG, 16'h8000);
    settle();
    rd(pm_pkg::PTR_CFG, 16'hffff, pm_pkg::CFG_RST);
    rd(pm_pkg::PTR_CAL, 16'hffff, 16'h0000);
    rd(pm_pkg::PTR_CURRENT, 16'hffff, 16'h0000);
    give_verdict();
  end
endmodule // testbench
